// ==== shared/mpb_pkg.sv ====
package mpb_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_TARGET_POSITION = 8'h00;
  localparam logic [7:0] OFF_START_SPEED = 8'h04;
  localparam logic [7:0] OFF_OPERATING_SPEED = 8'h08;
  localparam logic [7:0] OFF_ACCELERATION_RATE = 8'h0C;
  localparam logic [7:0] OFF_DECELERATION_RATE = 8'h10;
  localparam logic [7:0] OFF_SPEED_MAGNIFICATION = 8'h14;
  localparam logic [7:0] OFF_RAMP_DOWN_POINT = 8'h18;
  localparam logic [7:0] OFF_OP_MODE = 8'h1C;
  localparam logic [7:0] OFF_CMP_WORKING_VALUE = 8'h20;
  localparam logic [7:0] OFF_CMP_QUEUE_ENTRY = 8'h24;
  localparam logic [7:0] OFF_EXTENSION_STATUS = 8'h28;
  localparam logic [7:0] OFF_MAIN_STATUS_WORD = 8'h2C;
  localparam logic [7:0] OFF_EVENT_CAUSE_ENABLE = 8'h30;
  localparam logic [7:0] OFF_COMMAND = 8'h34;
  // field widths and positions
  localparam int SPEED_W = 16;
  localparam int MAG_W = 12;
  localparam int RAMP_W = 24;
  localparam int POS_RAMP_DOWN_MODE = 13;
  localparam int POS_FILL_LSB = 0;
  localparam int POS_FULL_FLAG = 0;
  localparam int POS_DRAIN_EVENT = 1;
  localparam int POS_DRAIN_IRQ_EN = 0;
  // commands and fill levels
  localparam logic [7:0] CMD_CMP_QUEUE_CANCEL = 8'h27;
  localparam logic [1:0] FILL_EMPTY = 2'h0;
  localparam logic [1:0] FILL_ONE = 2'h1;
  localparam logic [1:0] FILL_TWO = 2'h2;
  localparam logic [1:0] FILL_FULL = 2'h3;
  // reset value and response codes
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] target_position;
    logic [SPEED_W-1:0] start_speed;
    logic [SPEED_W-1:0] operating_speed;
    logic [SPEED_W-1:0] acceleration_rate;
    logic [SPEED_W-1:0] effective_decel_rate;
    logic [MAG_W-1:0] speed_magnification;
    logic [RAMP_W-1:0] ramp_down_point;
    logic ramp_down_mode_bit;
  } mpb_params_type;

  typedef struct packed {
    logic target_override;
    logic speed_override;
  } mpb_override_type;
endpackage : mpb_pkg

// ==== hw/mpb_bank.sv ====
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - working compare write replaces value at once
// - only queue entry writes mark stages valid
// - fill counts entries, advance decrements
// - full flag set exactly when fill is 11
// - rising compare result shifts queue forward when fill is 2 or more
// - compare writes accepted stopped or moving
// - interrupt when second stage drains, if enabled
// - cancel 27h empties queue, keeps working value
// - reset clears every register and stage
// - target position is full 32-bit signed
// - target write in motion overrides feed
// - start speed uses low 16 bits
// - operating speed write in motion retargets
// - acceleration rate holds 16 bits
// - zero deceleration rate uses acceleration rate
// - reserved bits ignore writes, read zero
// - sign bits ignore writes, copy top bit in mode 0, read zero in mode 1
// - magnification uses low 12 bits
// - pulse rate is speed times magnification factor
// - ramp upper byte follows ramp-down mode bit
// - mode 0: signed offset to automatic point
// - mode 1: decelerate when remaining below value
module mpb_bank (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic motion_active,
  input wire logic cmp_condition_set,
  input wire logic cmp_result,
  input wire logic [31:0] remaining_pulses,
  input wire logic [23:0] auto_ramp_point,
  output mpb_pkg::mpb_params_type params,
  output mpb_pkg::mpb_override_type overrides,
  output logic [31:0] cmp_compare_value,
  output logic decel_start,
  output logic int_n
);
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_ok;
  logic [31:0] wr_value;

  logic [31:0] target_position;
  logic [15:0] start_speed;
  logic [15:0] operating_speed;
  logic [15:0] acceleration_rate;
  logic [15:0] deceleration_rate;
  logic [11:0] speed_magnification;
  logic [23:0] ramp_down_point;
  logic ramp_down_mode_bit;
  logic cmp_queue_drain_irq_enable;
  logic drain_event;

  logic [31:0] cmp_working_value;
  logic [31:0] cmp_stage1;
  logic [31:0] cmp_stage2;
  logic [1:0] cmp_queue_fill;
  logic cmp_result_q;
  logic [31:0] next_working;
  logic [31:0] next_stage1;
  logic [31:0] next_stage2;
  logic [1:0] next_fill;

  logic wr_work;
  logic wr_entry;
  logic cancel;
  logic advance;
  logic drain_set;
  logic cmp_queue_full_flag;
  logic read_ok;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // write channel: address and data taken in either order, held until both present
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (do_write)
    begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      w_held <= 1'b0;
      w_data <= mpb_pkg::RESET_WORD;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (do_write)
    begin
      w_held <= 1'b0;
    end
  end

  always_comb
  begin
    unique case (aw_addr)
      mpb_pkg::OFF_TARGET_POSITION, mpb_pkg::OFF_START_SPEED,
      mpb_pkg::OFF_OPERATING_SPEED, mpb_pkg::OFF_ACCELERATION_RATE,
      mpb_pkg::OFF_DECELERATION_RATE, mpb_pkg::OFF_SPEED_MAGNIFICATION,
      mpb_pkg::OFF_RAMP_DOWN_POINT, mpb_pkg::OFF_OP_MODE,
      mpb_pkg::OFF_CMP_WORKING_VALUE, mpb_pkg::OFF_CMP_QUEUE_ENTRY,
      mpb_pkg::OFF_MAIN_STATUS_WORD, mpb_pkg::OFF_EVENT_CAUSE_ENABLE,
      mpb_pkg::OFF_COMMAND: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mpb_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? mpb_pkg::RESP_OKAY : mpb_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // byte lanes merged into a full word; narrow registers then drop upper bits
  // a process, not an assign, so register changes seen inside the function re-trigger it
  always_comb
  begin
    wr_value = merge_bytes(read_word_of(aw_addr), w_data, w_strb);
  end

  function automatic logic [31:0] read_word_of(input logic [7:0] a);
    logic [31:0] r;
    r = mpb_pkg::RESET_WORD;
    unique case (a)
      mpb_pkg::OFF_TARGET_POSITION: r = target_position;
      mpb_pkg::OFF_START_SPEED: r = {16'h0000, start_speed};
      mpb_pkg::OFF_OPERATING_SPEED: r = {16'h0000, operating_speed};
      mpb_pkg::OFF_ACCELERATION_RATE: r = {16'h0000, acceleration_rate};
      mpb_pkg::OFF_DECELERATION_RATE: r = {16'h0000, deceleration_rate};
      mpb_pkg::OFF_SPEED_MAGNIFICATION: r = {20'h00000, speed_magnification};
      // upper byte is never stored; it is rebuilt on read
      mpb_pkg::OFF_RAMP_DOWN_POINT:
        r = {ramp_down_mode_bit ? 8'h00 : {8{ramp_down_point[23]}}, ramp_down_point};
      mpb_pkg::OFF_OP_MODE: r = 32'(ramp_down_mode_bit) << mpb_pkg::POS_RAMP_DOWN_MODE;
      mpb_pkg::OFF_CMP_WORKING_VALUE: r = cmp_working_value;
      mpb_pkg::OFF_EXTENSION_STATUS: r = 32'(cmp_queue_fill) << mpb_pkg::POS_FILL_LSB;
      mpb_pkg::OFF_MAIN_STATUS_WORD:
        r = (32'(cmp_queue_full_flag) << mpb_pkg::POS_FULL_FLAG)
            | (32'(drain_event) << mpb_pkg::POS_DRAIN_EVENT);
      mpb_pkg::OFF_EVENT_CAUSE_ENABLE:
        r = 32'(cmp_queue_drain_irq_enable) << mpb_pkg::POS_DRAIN_IRQ_EN;
      default: r = mpb_pkg::RESET_WORD;
    endcase
    return r;
  endfunction : read_word_of

  // motion parameters, no gating on motion state
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      target_position <= mpb_pkg::RESET_WORD;
      start_speed <= 16'h0000;
      operating_speed <= 16'h0000;
      acceleration_rate <= 16'h0000;
      deceleration_rate <= 16'h0000;
      speed_magnification <= 12'h000;
      ramp_down_point <= 24'h000000;
      ramp_down_mode_bit <= 1'b0;
      cmp_queue_drain_irq_enable <= 1'b0;
    end
    else if (do_write)
    begin
      unique case (aw_addr)
        mpb_pkg::OFF_TARGET_POSITION: target_position <= wr_value;
        mpb_pkg::OFF_START_SPEED: start_speed <= wr_value[15:0];
        mpb_pkg::OFF_OPERATING_SPEED: operating_speed <= wr_value[15:0];
        mpb_pkg::OFF_ACCELERATION_RATE: acceleration_rate <= wr_value[15:0];
        mpb_pkg::OFF_DECELERATION_RATE: deceleration_rate <= wr_value[15:0];
        mpb_pkg::OFF_SPEED_MAGNIFICATION: speed_magnification <= wr_value[11:0];
        mpb_pkg::OFF_RAMP_DOWN_POINT: ramp_down_point <= wr_value[23:0];
        mpb_pkg::OFF_OP_MODE:
          ramp_down_mode_bit <= wr_value[mpb_pkg::POS_RAMP_DOWN_MODE];
        mpb_pkg::OFF_EVENT_CAUSE_ENABLE:
          cmp_queue_drain_irq_enable <= wr_value[mpb_pkg::POS_DRAIN_IRQ_EN];
        default: ;
      endcase
    end
  end

  // one-cycle override strobes to the pulse generator while moving
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      overrides <= '0;
    end
    else
    begin
      overrides.target_override <= do_write && motion_active
                                   && aw_addr == mpb_pkg::OFF_TARGET_POSITION;
      overrides.speed_override <= do_write && motion_active
                                  && aw_addr == mpb_pkg::OFF_OPERATING_SPEED;
    end
  end

  // pulse generator forms rate = speed * f(magnification); setting travels unscaled
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      params <= '0;
    end
    else
    begin
      params.target_position <= target_position;
      params.start_speed <= start_speed;
      params.operating_speed <= operating_speed;
      params.acceleration_rate <= acceleration_rate;
      params.effective_decel_rate <= (deceleration_rate == 16'h0000)
                                     ? acceleration_rate : deceleration_rate;
      params.speed_magnification <= speed_magnification;
      params.ramp_down_point <= ramp_down_point;
      params.ramp_down_mode_bit <= ramp_down_mode_bit;
    end
  end

  // ramp-down start; 33-bit signed sum avoids wrap at the extremes
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      decel_start <= 1'b0;
    end
    else if (ramp_down_mode_bit)
    begin
      decel_start <= remaining_pulses < {8'h00, ramp_down_point};
    end
    else
    begin
      decel_start <= $signed({1'b0, remaining_pulses})
                     <= $signed({9'h000, auto_ramp_point})
                        + $signed({{9{ramp_down_point[23]}}, ramp_down_point});
    end
  end

  // compare queue
  assign wr_work = do_write && aw_addr == mpb_pkg::OFF_CMP_WORKING_VALUE;
  assign wr_entry = do_write && aw_addr == mpb_pkg::OFF_CMP_QUEUE_ENTRY;
  assign cancel = do_write && aw_addr == mpb_pkg::OFF_COMMAND
                  && wr_value[7:0] == mpb_pkg::CMD_CMP_QUEUE_CANCEL;
  assign advance = cmp_condition_set && cmp_result && !cmp_result_q
                   && cmp_queue_fill >= mpb_pkg::FILL_TWO;
  assign cmp_queue_full_flag = cmp_queue_fill == mpb_pkg::FILL_FULL;
  assign cmp_compare_value = cmp_working_value;

  always_comb
  begin
    next_working = cmp_working_value;
    next_stage1 = cmp_stage1;
    next_stage2 = cmp_stage2;
    next_fill = cmp_queue_fill;
    if (advance)
    begin
      next_working = cmp_stage1;
      next_stage1 = cmp_stage2;
      next_fill = cmp_queue_fill - 2'h1;
    end
    if (wr_work)
    begin
      next_working = wr_value;
    end
    // entry writes land after a same-cycle advance so nothing is lost
    if (wr_entry)
    begin
      unique case (next_fill)
        mpb_pkg::FILL_EMPTY:
        begin
          next_working = wr_value;
          next_fill = mpb_pkg::FILL_ONE;
        end
        mpb_pkg::FILL_ONE:
        begin
          next_stage1 = wr_value;
          next_fill = mpb_pkg::FILL_TWO;
        end
        mpb_pkg::FILL_TWO:
        begin
          next_stage2 = wr_value;
          next_fill = mpb_pkg::FILL_FULL;
        end
        mpb_pkg::FILL_FULL: ; // host keeps off a full queue
      endcase
    end
    if (cancel)
    begin
      next_fill = (next_fill != mpb_pkg::FILL_EMPTY) ? mpb_pkg::FILL_ONE
                  : mpb_pkg::FILL_EMPTY;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cmp_working_value <= mpb_pkg::RESET_WORD;
      cmp_stage1 <= mpb_pkg::RESET_WORD;
      cmp_stage2 <= mpb_pkg::RESET_WORD;
      cmp_queue_fill <= mpb_pkg::FILL_EMPTY;
      cmp_result_q <= 1'b0;
    end
    else
    begin
      cmp_working_value <= next_working;
      cmp_stage1 <= next_stage1;
      cmp_stage2 <= next_stage2;
      cmp_queue_fill <= next_fill;
      cmp_result_q <= cmp_result;
    end
  end

  // drain event: sticky, write-one-to-clear, a new drain wins over the clear
  assign drain_set = advance && cmp_queue_fill == mpb_pkg::FILL_FULL
                     && cmp_queue_drain_irq_enable;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      drain_event <= 1'b0;
    end
    else if (drain_set)
    begin
      drain_event <= 1'b1;
    end
    else if (do_write && aw_addr == mpb_pkg::OFF_MAIN_STATUS_WORD
             && wr_value[mpb_pkg::POS_DRAIN_EVENT])
    begin
      drain_event <= 1'b0;
    end
  end

  assign int_n = !drain_event;

  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign read_ok = !(s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > mpb_pkg::OFF_COMMAND);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= mpb_pkg::RESET_WORD;
      s_axi_rresp <= mpb_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_word_of(s_axi_araddr);
      s_axi_rresp <= read_ok ? mpb_pkg::RESP_OKAY : mpb_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  a_full_flag: assert property (@(posedge mclk) disable iff (rst)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == mpb_pkg::OFF_MAIN_STATUS_WORD)
    |=> s_axi_rdata[0] == ($past(cmp_queue_fill) == 2'h3))
    else $error("full flag read disagrees with fill");
  a_fill_count_up: assert property (@(posedge mclk) disable iff (rst)
    (wr_entry && !advance && !cancel && cmp_queue_fill != 2'h3)
    |=> cmp_queue_fill == $past(cmp_queue_fill) + 2'h1)
    else $error("fill did not count an entry write");
  a_advance_shift: assert property (@(posedge mclk) disable iff (rst)
    (advance && !wr_work && !wr_entry)
    |=> cmp_working_value == $past(cmp_stage1) && cmp_stage1 == $past(cmp_stage2))
    else $error("queue did not shift on advance");
  a_work_bypass: assert property (@(posedge mclk) disable iff (rst)
    (wr_work && !wr_entry) |=> cmp_working_value == $past(wr_value))
    else $error("working compare write not applied");
  a_work_no_fill: assert property (@(posedge mclk) disable iff (rst)
    (wr_work && !wr_entry && !advance && !cancel) |=> $stable(cmp_queue_fill))
    else $error("working write changed fill");
  a_cancel_fill: assert property (@(posedge mclk) disable iff (rst)
    (cancel && !wr_entry && cmp_queue_fill > 2'h1 && !advance && !wr_work)
    |=> cmp_queue_fill == 2'h1 && $stable(cmp_working_value))
    else $error("cancel did not empty queue");
  a_drain_irq: assert property (@(posedge mclk) disable iff (rst)
    drain_set |=> !int_n [*2])
    else $error("interrupt missing after drain");
  a_decel_fallback: assert property (@(posedge mclk) disable iff (rst)
    (deceleration_rate == 16'h0000) |=> params.effective_decel_rate == $past(acceleration_rate))
    else $error("zero decel rate not replaced");
  a_ramp_mode_one: assert property (@(posedge mclk) disable iff (rst)
    (ramp_down_mode_bit && remaining_pulses < {8'h00, ramp_down_point}) |=> decel_start)
    else $error("ramp-down not started in mode 1");
  a_write_resp: assert property (@(posedge mclk) disable iff (rst)
    do_write |=> s_axi_bvalid)
    else $error("write response missing");

  c_queue_full: cover property (@(posedge mclk) disable iff (rst)
    cmp_queue_fill == 2'h3);
  c_drain_advance: cover property (@(posedge mclk) disable iff (rst) drain_set);
  c_cancel_queue: cover property (@(posedge mclk) disable iff (rst)
    cancel && cmp_queue_fill == 2'h3);
endmodule : mpb_bank

// ==== tb/mpb_motion_model.sv ====
`timescale 1ns/10ps
// stands in for the pulse generator and comparator beside the bank
module mpb_motion_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  input wire logic trig,
  input wire logic [31:0] start_count,
  output logic motion_active,
  output logic cmp_condition_set,
  output logic cmp_result,
  output logic [31:0] remaining_pulses,
  output logic [23:0] auto_ramp_point
);
  // condition always configured, so every rise of the result counts
  assign cmp_condition_set = 1'b1;
  assign auto_ramp_point = 24'h000040;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      motion_active <= 1'b0;
      cmp_result <= 1'b0;
      remaining_pulses <= 32'h0000_0000;
    end
    else
    begin
      motion_active <= run;
      cmp_result <= trig;
      // count reloads while stopped, runs down one pulse a cycle
      if (!run)
        remaining_pulses <= start_count;
      else if (remaining_pulses != 32'h0000_0000)
        remaining_pulses <= remaining_pulses - 32'h0000_0001;
    end
  end
endmodule : mpb_motion_model

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic motion_active;
  logic cmp_condition_set;
  logic cmp_result;
  logic [31:0] remaining_pulses;
  logic [23:0] auto_ramp_point;
  mpb_pkg::mpb_params_type params;
  mpb_pkg::mpb_override_type overrides;
  logic [31:0] cmp_compare_value;
  logic decel_start;
  logic int_n;
  logic run = 1'b0;
  logic trig = 1'b0;
  int fails = 0;
  int n_tests = 0;
  int n_ovr = 0;

  always #25 mclk = ~mclk;

  always @(posedge mclk)
    n_ovr <= n_ovr + int'(overrides.target_override === 1'b1)
      + int'(overrides.speed_override === 1'b1);

  mpb_bank i_mpb_bank (
    .mclk(mclk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .motion_active(motion_active), .cmp_condition_set(cmp_condition_set),
    .cmp_result(cmp_result), .remaining_pulses(remaining_pulses),
    .auto_ramp_point(auto_ramp_point), .params(params), .overrides(overrides),
    .cmp_compare_value(cmp_compare_value), .decel_start(decel_start),
    .int_n(int_n)
  );

  mpb_motion_model i_mpb_motion_model (
    .mclk(mclk), .rst(rst), .run(run), .trig(trig),
    .start_count(32'h0000_0104), .motion_active(motion_active),
    .cmp_condition_set(cmp_condition_set), .cmp_result(cmp_result),
    .remaining_pulses(remaining_pulses), .auto_ramp_point(auto_ramp_point)
  );

  task automatic final_report();
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge mclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        return;
      end
    end
    fails++;
    final_report();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int i;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge mclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        rready <= 1'b0;
        chk("rdata", e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        return;
      end
    end
    fails++;
    final_report();
  endtask : rd

  task automatic t_reset();
    logic [7:0] offs [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
      8'h1C, 8'h20, 8'h28, 8'h2C};
    foreach (offs[i])
      rd(offs[i], 32'h0000_0000, mpb_pkg::RESP_OKAY);
    chk("int_n", 32'h1, {31'h0, int_n});
  endtask : t_reset

  task automatic t_fields();
    wr(mpb_pkg::OFF_TARGET_POSITION, 32'h8000_0000, mpb_pkg::RESP_OKAY);
    rd(mpb_pkg::OFF_TARGET_POSITION, 32'h8000_0000, mpb_pkg::RESP_OKAY);
    chk("pos", 32'h8000_0000, params.target_position);
    wr(mpb_pkg::OFF_START_SPEED, 32'hFFFF_FFFF, mpb_pkg::RESP_OKAY);
    rd(mpb_pkg::OFF_START_SPEED, 32'h0000_FFFF, mpb_pkg::RESP_OKAY);
    chk("fl", 32'h0000_FFFF, {16'h0, params.start_speed});
    wr(mpb_pkg::OFF_OPERATING_SPEED, 32'hABCD_1234, mpb_pkg::RESP_OKAY);
    rd(mpb_pkg::OFF_OPERATING_SPEED, 32'h0000_1234, mpb_pkg::RESP_OKAY);
    chk("fh", 32'h0000_1234, {16'h0, params.operating_speed});
    wr(mpb_pkg::OFF_ACCELERATION_RATE, 32'h1234_0005, mpb_pkg::RESP_OKAY);
    rd(mpb_pkg::OFF_ACCELERATION_RATE, 32'h0000_0005, mpb_pkg::RESP_OKAY);
    wr(mpb_pkg::OFF_SPEED_MAGNIFICATION, 32'hFFFF_FFFF, mpb_pkg::RESP_OKAY);
    rd(mpb_pkg::OFF_SPEED_MAGNIFICATION, 32'h0000_0FFF, mpb_pkg::RESP_OKAY);
    chk("mag", 32'h0FFF, {20'h0, params.speed_magnification});
    repeat (2) @(posedge mclk);
    chk("decel", 32'h0005, {16'h0, params.effective_decel_rate});
    wr(mpb_pkg::OFF_DECELERATION_RATE, 32'h0000_0007, mpb_pkg::RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk("decel", 32'h0007, {16'h0, params.effective_decel_rate});
  endtask : t_fields

  task automatic t_ramp();
    wr(mpb_pkg::OFF_RAMP_DOWN_POINT, 32'h0080_0000, mpb_pkg::RESP_OKAY);
    rd(mpb_pkg::OFF_RAMP_DOWN_POINT, 32'hFF80_0000, mpb_pkg::RESP_OKAY);
    // most negative offset pushes the point below zero: no ramp-down yet
    chk("decel_start", 32'h0, {31'h0, decel_start});
    wr(mpb_pkg::OFF_OP_MODE, 32'h0000_2000, mpb_pkg::RESP_OKAY);
    rd(mpb_pkg::OFF_RAMP_DOWN_POINT, 32'h0080_0000, mpb_pkg::RESP_OKAY);
    wr(mpb_pkg::OFF_RAMP_DOWN_POINT, 32'h0000_0100, mpb_pkg::RESP_OKAY);
    run <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("decel_start", 32'h0, {31'h0, decel_start});
    repeat (20) @(posedge mclk);
    chk("decel_start", 32'h1, {31'h0, decel_start});
    run <= 1'b0;
    // mode 0 again: offset 100h on auto point 40h covers the reloaded 104h count
    wr(mpb_pkg::OFF_OP_MODE, 32'h0000_0000, mpb_pkg::RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk("decel_start", 32'h1, {31'h0, decel_start});
  endtask : t_ramp

  task automatic t_override();
    int base;
    repeat (3) @(posedge mclk);
    base = n_ovr;
    wr(mpb_pkg::OFF_TARGET_POSITION, 32'h0000_0010, mpb_pkg::RESP_OKAY);
    repeat (3) @(posedge mclk);
    chk("ovr idle", base, n_ovr);
    run <= 1'b1;
    repeat (2) @(posedge mclk);
    wr(mpb_pkg::OFF_TARGET_POSITION, 32'h0000_0020, mpb_pkg::RESP_OKAY);
    wr(mpb_pkg::OFF_OPERATING_SPEED, 32'h0000_0030, mpb_pkg::RESP_OKAY);
    repeat (3) @(posedge mclk);
    chk("ovr moving", base + 2, n_ovr);
  endtask : t_override

  task automatic t_queue();
    int i;
    // axis still moving here, compare writes must land anyway
    wr(mpb_pkg::OFF_EVENT_CAUSE_ENABLE, 32'h0000_0001, mpb_pkg::RESP_OKAY);
    for (i = 1; i <= 3; i++)
    begin
      wr(mpb_pkg::OFF_CMP_QUEUE_ENTRY, 32'h0000_00C0 + i, mpb_pkg::RESP_OKAY);
      rd(mpb_pkg::OFF_EXTENSION_STATUS, i, mpb_pkg::RESP_OKAY);
      rd(mpb_pkg::OFF_MAIN_STATUS_WORD, int'(i == 3), mpb_pkg::RESP_OKAY);
    end
    chk("cmp", 32'h0000_00C1, cmp_compare_value);
    trig <= 1'b1;
    repeat (4) @(posedge mclk);
    trig <= 1'b0;
    chk("cmp", 32'h0000_00C2, cmp_compare_value);
    rd(mpb_pkg::OFF_EXTENSION_STATUS, 32'h2, mpb_pkg::RESP_OKAY);
    rd(mpb_pkg::OFF_MAIN_STATUS_WORD, 32'h2, mpb_pkg::RESP_OKAY);
    chk("int_n", 32'h0, {31'h0, int_n});
    wr(mpb_pkg::OFF_MAIN_STATUS_WORD, 32'h0000_0002, mpb_pkg::RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk("int_n", 32'h1, {31'h0, int_n});
    // queue holds two now, so one more entry is legal
    wr(mpb_pkg::OFF_CMP_QUEUE_ENTRY, 32'h0000_00C4, mpb_pkg::RESP_OKAY);
    rd(mpb_pkg::OFF_EXTENSION_STATUS, 32'h3, mpb_pkg::RESP_OKAY);
    wr(mpb_pkg::OFF_COMMAND, {24'h0, mpb_pkg::CMD_CMP_QUEUE_CANCEL}, mpb_pkg::RESP_OKAY);
    rd(mpb_pkg::OFF_EXTENSION_STATUS, 32'h1, mpb_pkg::RESP_OKAY);
    chk("cmp", 32'h0000_00C2, cmp_compare_value);
    wr(mpb_pkg::OFF_CMP_WORKING_VALUE, 32'h5555_0000, mpb_pkg::RESP_OKAY);
    chk("cmp", 32'h5555_0000, cmp_compare_value);
    rd(mpb_pkg::OFF_EXTENSION_STATUS, 32'h1, mpb_pkg::RESP_OKAY);
    run <= 1'b0;
  endtask : t_queue

  task automatic t_bus_err();
    rd(8'h40, 32'h0000_0000, mpb_pkg::RESP_SLVERR);
    wr(mpb_pkg::OFF_EXTENSION_STATUS, 32'h0000_0003, mpb_pkg::RESP_SLVERR);
    rd(mpb_pkg::OFF_EXTENSION_STATUS, 32'h1, mpb_pkg::RESP_OKAY);
  endtask : t_bus_err

  initial
  begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_fields();
    t_ramp();
    t_override();
    t_queue();
    t_bus_err();
    final_report();
  end
endmodule : tb
